// [rtl/teq_pkg.sv]
/*
 * Constants for the timed output event queue: image lengths, entry layout,
 * queue depth, status bit positions and microsecond ticker timing.
 * Assumes a single 100 MHz clock domain.
 */
package teq_pkg;
    // Image lengths, in bytes
    localparam logic [7:0] IN_IMAGE_LEN    = 8'h04;
    localparam logic [7:0] OUT_IMAGE_SHORT = 8'h14;
    localparam logic [7:0] OUT_IMAGE_LONG  = 8'h3c;

    // Entry layout inside the output image, four bytes per entry
    localparam int         ENTRY_BYTES   = 4;
    localparam logic [1:0] OFS_STATE     = 2'h0;
    localparam logic [1:0] OFS_RECORD    = 2'h1;
    localparam logic [1:0] OFS_TIME_LO   = 2'h2;
    localparam logic [1:0] OFS_TIME_HI   = 2'h3;
    localparam int         OUT_ADDR_W    = 6;
    localparam int         TIME_W        = 16;
    localparam int         ENTRY_W       = 32;

    // Output state bits: output 0 takes bit 7 down to output 3 on bit 4
    localparam int         NUM_OUTPUTS   = 4;
    localparam int         STATE_TOP_BIT = 7;

    // Queue sizing
    localparam int         QUEUE_DEPTH   = 31;
    localparam int         COUNT_W       = 5;

    // Queue status byte bit positions
    localparam int         STS_EMPTY     = 0;
    localparam int         STS_FULL      = 1;
    localparam int         STS_OVERFLOW  = 2;

    // Microsecond ticker
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         TICK_US       = 1;
    localparam int         TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
    localparam int         TICK_CNT_W    = 7;

    typedef struct packed {
        logic [7:0]        state;
        logic [7:0]        record;
        logic [TIME_W-1:0] time_us;
    } teq_entry_t;
endpackage

// [rtl/teq_queue_if.sv]
/*
 * Interface joining the event queue control logic to its FIFO.
 * Assumes both ends run on the same clock.
 */
interface teq_queue_if;
    import teq_pkg::*;
    logic               push_valid;
    logic               push_ready;
    teq_entry_t         push_data;
    logic               pop_valid;
    logic               pop_ready;
    teq_entry_t         pop_data;
    logic [COUNT_W-1:0] count;

    modport ctrl (output push_valid, input push_ready, output push_data,
                  input pop_valid, output pop_ready, input pop_data, input count);
    modport fifo (input push_valid, output push_ready, input push_data,
                  output pop_valid, input pop_ready, output pop_data, output count);
endinterface

// [rtl/teq_fifo.sv]
/*
 * Entry FIFO of the timed output event queue, width and depth parameters.
 * Assumes an asynchronous active-low reset whose release is already synchronised.
 */
module teq_fifo #(
    parameter int WIDTH = teq_pkg::ENTRY_W,
    parameter int DEPTH = teq_pkg::QUEUE_DEPTH
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    teq_queue_if.fifo  q
);
    import teq_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   fill;

    wire do_push = q.push_valid && q.push_ready;
    wire do_pop  = q.pop_valid && q.pop_ready;
    wire [PTR_W-1:0] wr_inc = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [PTR_W-1:0] rd_inc = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    // Full and empty come from the fill level, so they never lie
    assign q.push_ready = (fill != (PTR_W+1)'(DEPTH));
    assign q.pop_valid  = (fill != '0);
    assign q.pop_data   = mem[rd_ptr];
    assign q.count      = COUNT_W'(fill);

    // Slots start cleared and are cleared again once drained
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_slot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    mem[gi] <= '0;                                        // [R9]
                else if (do_push && wr_ptr == PTR_W'(gi))
                    mem[gi] <= q.push_data;                               // [R4]
                else if (do_pop && rd_ptr == PTR_W'(gi))
                    mem[gi] <= '0;                                        // [R9]
            end
        end
    endgenerate

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (do_push)
                wr_ptr <= wr_inc;
            if (do_pop)
                rd_ptr <= rd_inc;                                         // [R8]
            if (do_push && !do_pop)
                fill <= fill + 1'b1;
            else if (do_pop && !do_push)
                fill <= fill - 1'b1;
        end
    end
endmodule

// [rtl/teq_top.sv]
/*
 * Timed output event queue: collects four-byte entries written into the
 * output image, queues them, and drives four outputs when the microsecond
 * ticker reaches each entry's time. Status comes back in the input image.
 * Assumes image writes come from logic on ref_clk; the variant strap is a pin.
 */
// Behaviour
// [R1] The input image length reads a fixed four bytes.
// [R2] The output image length reads 20 or 60 bytes by the strapped variant.
// [R3] The host moves the parameter set only while its system is stopped.
// [R4] Entries written into the output image are queued at once, in order.
// [R5] Each entry takes four bytes: state, record number, time in microseconds.
// [R6] At the entry's time the four outputs follow state bits 7 down to 4.
// [R7] The input image returns last and next record, queue status and count.
// [R8] An applied entry leaves the queue and the next one becomes the head.
// [R9] The queue holds 31 entries and emptied slots read as zero.
module teq_top (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic                        variant_long,
    input  wire logic                        out_img_wr,
    input  wire logic [teq_pkg::OUT_ADDR_W-1:0] out_img_addr,
    input  wire logic [7:0]                  out_img_data,
    input  wire logic                        out_img_busy_ack,
    output logic      [teq_pkg::NUM_OUTPUTS-1:0] do_out,
    output logic      [7:0]                  last_record_number,
    output logic      [7:0]                  next_record_number,
    output logic      [7:0]                  queue_status_byte,
    output logic      [7:0]                  stored_entry_count,
    output logic      [7:0]                  input_image_length,
    output logic      [7:0]                  output_image_length,
    output logic                             out_img_ready
);
    import teq_pkg::*;

    logic [1:0]            rst_sync;
    logic [2:0]            strap_sync;
    logic [2:0]            strap_seen;
    logic                  strap_taken;
    logic [TICK_CNT_W-1:0] tick_div;
    logic [TIME_W-1:0]     ticker_us;
    logic [7:0]            stage_state;
    logic [7:0]            stage_record;
    logic [7:0]            stage_time_lo;
    logic                  overflow;
    logic                  push_pend;
    teq_entry_t            push_entry;

    wire rst_n = rst_sync[1];

    teq_queue_if q ();

    teq_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_fifo (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .q     (q)
    );

    // Reset released through two flip-flops, asserted at once
    // The release is synchronous so no flop leaves reset on a different edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // Variant strap: three stages, taken once stages two and three agree.
    // The fill marks keep the reset zeros of the stages from counting as an
    // agreement, which would otherwise lock a long variant to the short image
    wire strap_agree = strap_seen[2] && !strap_taken && (strap_sync[1] == strap_sync[2]);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync          <= 3'h0;
            strap_seen          <= 3'h0;
            strap_taken         <= 1'b0;
            input_image_length  <= IN_IMAGE_LEN;                          // [R1]
            output_image_length <= OUT_IMAGE_SHORT;
        end else begin
            strap_sync <= {strap_sync[1:0], variant_long};
            strap_seen <= {strap_seen[1:0], 1'b1};
            // Length is frozen after the first agreement; reconfiguring only
            // happens across a reset, matching the host's stopped-state transfer
            if (strap_agree) begin                                        // [R3]
                strap_taken         <= 1'b1;
                output_image_length <= strap_sync[2] ? OUT_IMAGE_LONG
                                                     : OUT_IMAGE_SHORT;   // [R2]
            end
        end
    end

    // Microsecond ticker, free running, wraps at the top of its range.
    // Times are absolute, so the host must schedule against this count;
    // only a reset moves it, and that restarts it at zero
    wire tick_end = (tick_div == TICK_CNT_W'(TICK_CYCLES - 1));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_div  <= '0;
            ticker_us <= '0;
        end else begin
            tick_div <= tick_end ? '0 : tick_div + 1'b1;
            if (tick_end)
                ticker_us <= ticker_us + 1'b1;
        end
    end

    // Byte decode of the output image; writes past the image length are dropped
    // Writes before the strap is taken are dropped too, the length is unsure then
    wire                   in_image  = ({2'h0, out_img_addr} < output_image_length);
    wire [1:0]             byte_sel  = out_img_addr[1:0];
    wire                   wr_ok     = out_img_wr && in_image && strap_taken && out_img_ready;
    wire                   wr_last   = wr_ok && (byte_sel == OFS_TIME_HI);           // [R5]
    wire                   push_done = q.push_valid && q.push_ready;

    // Staging of the first three bytes of an entry
    // A repeated byte at the same offset overwrites the staged one; only the
    // time high byte commits, so the other three may come in any order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_state   <= 8'h00;
            stage_record  <= 8'h00;
            stage_time_lo <= 8'h00;
        end else if (wr_ok) begin
            if (byte_sel == OFS_STATE)
                stage_state <= out_img_data;                              // [R5]
            if (byte_sel == OFS_RECORD)
                stage_record <= out_img_data;                             // [R5]
            if (byte_sel == OFS_TIME_LO)
                stage_time_lo <= out_img_data;                            // [R5]
        end
    end

    // Completed entry waits one slot; a full queue holds it and stalls writes
    // One pending slot is enough because ready drops for a cycle after a commit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_pend  <= 1'b0;
            push_entry <= '0;
        end else if (wr_last) begin
            push_pend  <= 1'b1;                                           // [R4]
            push_entry <= '{state: stage_state, record: stage_record,
                            time_us: {out_img_data, stage_time_lo}};
        end else if (push_done) begin
            push_pend <= 1'b0;
        end
    end

    assign q.push_valid = push_pend;
    assign q.push_data  = push_entry;

    // Back-pressure to the writer while an entry cannot enter the queue or
    // the queue is full. Ready is registered, so a full queue is seen one
    // edge late; a first byte may still be staged then, but its entry cannot
    // commit before a slot drains
    wire ready_next = !(push_pend && !push_done) && !wr_last && q.push_ready;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            out_img_ready <= 1'b1;
        else
            out_img_ready <= ready_next;                                  // [R9]
    end

    // Head entry is due when the ticker equals its time
    // Equality, not a later-than test: a head whose time has passed waits for
    // the ticker to wrap, and every entry behind it waits as well
    wire due = q.pop_valid && (q.pop_data.time_us == ticker_us);          // [R6]
    assign q.pop_ready = due;                                             // [R8]

    // Outputs follow the due entry's state bits, bit 7 first. The bit pick is
    // a wire per output, so the output register stays one process
    wire [NUM_OUTPUTS-1:0] due_bits;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out
            assign due_bits[gi] = q.pop_data.state[STATE_TOP_BIT - gi];   // [R6]
        end
    endgenerate

    // Outputs hold their level between due entries
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            do_out <= '0;
        else if (due)
            do_out <= due_bits;                                           // [R6]
    end

    // Overflow is sticky until reset; a write made while out_img_ready is low is
    // dropped by wr_ok before staging, so it is lost without setting the flag
    wire refused = wr_last && push_pend && !push_done;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            overflow <= 1'b0;
        else if (refused)
            overflow <= 1'b1;
    end

    // Status bytes of the input image
    // All four come from one snapshot of the queue, one edge behind it, so a
    // reader never sees a count that disagrees with the empty or full bits
    wire [COUNT_W-1:0] next_count = q.count;
    wire               q_empty    = !q.pop_valid;
    wire               q_full     = !q.push_ready;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_record_number <= 8'h00;
            next_record_number <= 8'h00;
            queue_status_byte  <= 8'h00;
            stored_entry_count <= 8'h00;
        end else begin
            if (due)
                last_record_number <= q.pop_data.record;                 // [R7]
            next_record_number <= q.pop_data.record;                     // [R7]
            queue_status_byte  <= 8'h00;
            queue_status_byte[STS_EMPTY]    <= q_empty;                   // [R7]
            queue_status_byte[STS_FULL]     <= q_full;
            queue_status_byte[STS_OVERFLOW] <= overflow;
            stored_entry_count <= {{(8-COUNT_W){1'b0}}, next_count};     // [R7]
        end
    end
endmodule

// [tb/teq_chk.sv]
/* Port checks for the timed output event queue.
   Assumes one ref_clk domain; bound to teq_top below. */
module teq_chk (
    input wire logic                  ref_clk,
    input wire logic                  rst_b,
    input wire logic                  out_img_wr,
    input wire logic [teq_pkg::OUT_ADDR_W-1:0] out_img_addr,
    input wire logic                  out_img_ready,
    input wire logic [7:0]            last_record_number,
    input wire logic [7:0]            queue_status_byte,
    input wire logic [7:0]            stored_entry_count,
    input wire logic [7:0]            input_image_length,
    input wire logic [7:0]            output_image_length
);
    timeunit 1ns;
    timeprecision 1ps;
    import teq_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Byte +3 taken inside the image closes an entry
    wire commit = out_img_wr && out_img_ready && out_img_addr[1:0] == 2'h3
                  && 8'(out_img_addr) < output_image_length;

    // Quiet for a while, so the lagging status bytes have caught up
    sequence s_settled;
        (!out_img_wr && $stable(stored_entry_count) && $stable(last_record_number)
         && $stable(out_img_ready))[*6];
    endsequence
    sequence s_commit;
        commit && stored_entry_count < 8'h1e;
    endsequence
    sequence s_apply;
        $changed(last_record_number);
    endsequence

    AST_IN_LEN: assert property (input_image_length == IN_IMAGE_LEN)
        else $error("input length wrong");
    AST_OUT_LEN: assert property (output_image_length inside {8'h14, 8'h3c})
        else $error("output length wrong");
    AST_COUNT_MAX: assert property (stored_entry_count <= 8'h1f)
        else $error("count above depth");
    AST_STS_RSVD: assert property (queue_status_byte[7:3] == 5'h00)
        else $error("status spare bits set");
    AST_EMPTY: assert property (s_settled |-> queue_status_byte[STS_EMPTY]
                                == (stored_entry_count == 8'h00))
        else $error("empty bit wrong");
    AST_FULL: assert property (s_settled ##0 stored_entry_count == 8'h1f
                               |-> queue_status_byte[STS_FULL])
        else $error("full bit missing");
    AST_READY_DROP: assert property (s_commit |=> !out_img_ready)
        else $error("ready did not drop");
    AST_COUNT_RISE: assert property (s_commit |-> ##[2:6] $changed(stored_entry_count))
        else $error("entry not queued");
    AST_APPLY: assert property (s_apply |-> ##[1:3] $changed(stored_entry_count))
        else $error("applied entry kept");
endmodule

bind teq_top teq_chk i_teq_chk (.ref_clk, .rst_b, .out_img_wr, .out_img_addr, .out_img_ready,
    .last_record_number, .queue_status_byte, .stored_entry_count, .input_image_length,
    .output_image_length);

// [tb/teq_host_model.sv]
/* Host model writing four-byte entries into the output image.
   Assumes the bench top tb holds the verdict task. */
module teq_host_model (
    input  wire logic  clk,
    input  wire logic  ready,
    output logic       wr,
    output logic [5:0] addr,
    output logic [7:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr = 1'b0;
        addr = 6'h00;
        data = 8'h00;
    end

    // Streams entries only; parameter records are never sent while running
    task automatic write_entry(input logic [2:0] slot, input logic [7:0] st,
                               input logic [7:0] rec, input logic [15:0] tm);
        logic [7:0] b [4];
        int k;
        b = '{st, rec, tm[7:0], tm[15:8]};
        @(negedge clk);
        for (k = 0; k < 200 && ready !== 1'b1; k++) @(negedge clk);
        if (ready !== 1'b1) begin
            tb.n_fail++;
            tb.final_report();
        end
        // Bytes back to back; byte +3 commits the entry
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            wr <= 1'b1;
            addr <= {slot, 2'(k)};
            data <= b[k];
        end
        // Released lines show the inverse so stale values cannot pass
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~addr;
        data <= ~data;
    endtask
endmodule

// [tb/tb.sv]
/* Self-checking bench for the timed output event queue.
   Assumes the host model drives all image writes. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import teq_pkg::*;
    logic        ref_clk, rst_b, variant_long, out_img_busy_ack, out_img_wr, out_img_ready;
    logic [5:0]  out_img_addr;
    logic [7:0]  out_img_data, last_record_number, next_record_number, queue_status_byte;
    logic [7:0]  stored_entry_count, input_image_length, output_image_length;
    logic [3:0]  do_out;
    logic [31:0] lfsr = 32'hc9fa;
    logic [31:0] exp_q[$];
    time         t0;
    int          n_fail = 0;
    int          tests_run = 0;

    teq_top i_teq_top (.ref_clk, .rst_b, .variant_long, .out_img_wr, .out_img_addr,
        .out_img_data, .out_img_busy_ack, .do_out, .last_record_number, .next_record_number,
        .queue_status_byte, .stored_entry_count, .input_image_length, .output_image_length,
        .out_img_ready);
    teq_host_model i_teq_host_model (.clk(ref_clk), .ready(out_img_ready), .wr(out_img_wr),
        .addr(out_img_addr), .data(out_img_data));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("mismatches=%0d checks=%0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Reset 20 cycles, then wait past strap capture before writing
    task automatic do_reset(input logic v);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        variant_long <= v;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        t0 = $time;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Random state nibble; kept entries go to the reference queue
    task automatic put(input logic [2:0] slot, input logic [7:0] rec, input logic [15:0] tm,
                       input bit keep);
        logic [7:0] st;
        lfsr = lfsr_next(lfsr);
        st = {lfsr[3:0], 4'h0};
        i_teq_host_model.write_entry(slot, st, rec, tm);
        if (keep) exp_q.push_back({st, rec, tm});
    endtask

    initial begin
        logic [31:0] e;
        int i, k;
        rst_b = 1'b0;
        variant_long = 1'b0;
        out_img_busy_ack = 1'b0;
        do_reset(1'b0);
        check(input_image_length, IN_IMAGE_LEN);
        check(output_image_length, OUT_IMAGE_SHORT);
        check(queue_status_byte, 8'h01);
        check(do_out, 32'h0);
        // Five entries, then one outside the short image that must be ignored
        for (i = 0; i < 5; i++) put(3'(i), 8'(i + 1), 16'(20 + 10 * i), 1'b1);
        put(3'h5, 8'h66, 16'h0019, 1'b0);
        repeat (4) @(negedge ref_clk);
        check(stored_entry_count, 8'h05);
        check(next_record_number, 8'h01);
        check(queue_status_byte, 8'h00);
        // Each entry applied at its time, then dropped
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            for (k = 0; k < 5000 && last_record_number !== e[23:16]; k++) @(negedge ref_clk);
            if (last_record_number !== e[23:16]) begin
                n_fail++;
                final_report();
            end
            check(($time - t0) / 1000, e[15:0]);
            check(do_out, {e[28], e[29], e[30], e[31]});
            repeat (3) @(negedge ref_clk);
            check(stored_entry_count, exp_q.size());
            check(next_record_number, exp_q.size() ? exp_q[0][23:16] : 8'h00);
        end
        check(queue_status_byte, 8'h01);
        // Fill to the limit with far-off times
        for (i = 0; i < 31; i++) put(3'(i % 5), 8'(8'h40 + i), 16'hff00, 1'b0);
        repeat (12) @(negedge ref_clk);
        check(stored_entry_count, 8'h1f);
        check(queue_status_byte[STS_FULL], 1'b1);
        check(out_img_ready, 1'b0);
        do_reset(1'b1);
        check(output_image_length, OUT_IMAGE_LONG);
        check(stored_entry_count, 8'h00);
        check(last_record_number, 8'h00);
        check(queue_status_byte, 8'h01);
        final_report();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule
